// *** logic/fpp_defs.svh ***
// Constants for the flash programming port host controller
// Notes on behaviour
// - Lock write: select low, preamble, E4, two zero bytes, data, select high.
// - After lock or fuse write wait programming time, busy pin, or status.
// - Lock read: preamble, 64, two zeros; last strobe held high.
// - Reads: release bus while strobe high, drop strobe, sample, raise select.
// - Fuse write: preamble, E1, two zero bytes, fuse data, select high.
// - Unimplemented fuse bit positions are always written as ones.
// - Fuse read: preamble, 61, two zeros, turnaround, fuse byte returned.
// - Status read: preamble, 60, two zeros, turnaround, status byte returned.
// - After busy falls wait at least 3 us before next write.
// - Serial sessions work only once the serial enable fuse is set.
// - Keep the serial clock below 5 MHz.
// - Power-up: SCK and SS low, wait 10 us, raise reset and SS, wait 2 ms.
// - Power-down: release MOSI, SCK low, reset low, SS low, then supply off; the code drops SS and supply in one step.
// - Enter serial mode: SS high, release MISO, reset high, SCK low; the code enables the MOSI driver in the second step instead.
// - Exit serial mode: SS high, release MOSI, SCK, reset low, release SS.
// - Serial bytes shift most significant bit first both ways.
// - Device updates MISO on SCK fall, samples MOSI on rise; host does the same with MOSI and MISO.
// - SS low before first serial byte, high after last; completes command.
// - Command bytes go out on MOSI, read bytes come back on MISO.
`ifndef FPP_DEFS_SVH
`define FPP_DEFS_SVH
`define FPP_PREAMBLE 8'haa
`define FPP_OP_LOCK_WR 8'he4
`define FPP_OP_LOCK_RD 8'h64
`define FPP_OP_FUSE_WR 8'he1
`define FPP_OP_FUSE_RD 8'h61
`define FPP_OP_STATUS 8'h60
`define FPP_ADDR_ZERO 8'h00
`define FPP_CLK_MHZ 40
`define FPP_T_STROBE_NS 125
`define FPP_STROBE_CYC ((`FPP_T_STROBE_NS * `FPP_CLK_MHZ + 999) / 1000)
`define FPP_T_PROG_US 4000
`define FPP_PROG_CYC (`FPP_T_PROG_US * `FPP_CLK_MHZ)
`define FPP_T_GAP_US 3
`define FPP_GAP_CYC (`FPP_T_GAP_US * `FPP_CLK_MHZ)
`define FPP_T_PWRUP_US 10
`define FPP_PWRUP_CYC (`FPP_T_PWRUP_US * `FPP_CLK_MHZ)
`define FPP_T_POR_US 2000
`define FPP_POR_CYC (`FPP_T_POR_US * `FPP_CLK_MHZ)
`define FPP_SCK_DIV 4
`endif

// *** logic/fpp_pkg.sv ***
// Types shared by the flash programming port host controller
package fpp_pkg;
  typedef enum logic [1:0] {
    FPP_CMD_LOCK_WR = 2'h0,
    FPP_CMD_LOCK_RD = 2'h1,
    FPP_CMD_FUSE_WR = 2'h2,
    FPP_CMD_FUSE_RD = 2'h3
  } fpp_cmd_t;
  typedef struct packed {
    logic serial;
    logic status;
    fpp_cmd_t cmd;
    logic [7:0] data;
  } fpp_req_t;
  typedef struct packed {
    logic sel_n;
    logic strobe;
    logic [7:0] dout;
    logic doe_n;
  } fpp_par_t;
endpackage

// *** logic/fpp_host.sv ***
// Host controller driving the flash programming port, parallel and serial
`timescale 1ns/1ps
`include "fpp_defs.svh"
module fpp_host
  import fpp_pkg::*;
#(
  parameter int PROG_CYC = `FPP_PROG_CYC,
  parameter int POR_CYC = `FPP_POR_CYC,
  parameter logic [7:0] FUSE_IMPL_MASK = 8'hff
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire fpp_req_t req,
  input wire logic pwr_up_req,
  input wire logic isp_enter_req,
  input wire logic isp_exit_req,
  input wire logic pwr_dn_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [7:0] par_dout,
  input wire logic [7:0] par_din,
  output logic par_doe_n,
  output logic select_pin,
  output logic program_strobe,
  input wire logic busy_indicator_pin,
  output logic sck_out,
  output logic sck_oe_n,
  output logic ss_out,
  output logic ss_oe_n,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic dev_reset,
  output logic vcc_en
);
  //////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_SETUP = 4'h1, S_HI = 4'h3, S_LO = 4'h2,
    S_TURN = 4'h6, S_SAMP = 4'h7, S_END = 4'h5, S_WAIT = 4'h4,
    S_GAP = 4'hc, S_SER = 4'hd, S_SEQ = 4'hf
  } fpp_st_t;
  fpp_st_t st_reg, st_next;
  logic [2:0] idx_reg;
  logic [31:0] cnt_reg;
  logic [7:0] byte_w;
  logic is_rd, is_wr;
  fpp_req_t cur_reg;
  logic [1:0] busy_s_reg, miso_s_reg;
  logic [2:0] seq_reg;
  logic [2:0] seq_kind_reg;
  logic [7:0] op_w;
  logic busy_sync, miso_sync;

  assign busy_sync = busy_s_reg[1];
  assign miso_sync = miso_s_reg[1];
  assign is_rd = cur_reg.status || cur_reg.cmd == FPP_CMD_LOCK_RD ||
                 cur_reg.cmd == FPP_CMD_FUSE_RD;
  assign is_wr = !is_rd;
  assign op_w = cur_reg.status ? `FPP_OP_STATUS :
                (cur_reg.cmd == FPP_CMD_LOCK_WR) ? `FPP_OP_LOCK_WR :
                (cur_reg.cmd == FPP_CMD_LOCK_RD) ? `FPP_OP_LOCK_RD :
                (cur_reg.cmd == FPP_CMD_FUSE_WR) ? `FPP_OP_FUSE_WR :
                `FPP_OP_FUSE_RD;
  // Unimplemented fuse positions forced high so software cannot clear them
  assign byte_w = (idx_reg == 3'd0) ? `FPP_PREAMBLE :
                  (idx_reg == 3'd1) ? op_w :
                  (idx_reg == 3'd4 && cur_reg.cmd == FPP_CMD_FUSE_WR) ?
                    (cur_reg.data | ~FUSE_IMPL_MASK) :
                  (idx_reg == 3'd4) ? cur_reg.data : `FPP_ADDR_ZERO;

  //////////////////////////////////////////////////////////////////////
  // Serial shifter on the link clock; words cross by toggle handshake
  logic go_tgl_reg, done_tgl_reg;
  logic [7:0] sh_tx_reg;
  logic [1:0] go_s_l, done_s_s;
  logic go_seen_l, done_seen_reg;
  logic [7:0] l_sh_reg, l_rx_reg;
  logic [3:0] l_bit_reg;
  logic l_sck_reg, l_act_reg, l_done_tgl;
  logic [7:0] rx_hold_reg;
  logic ser_done;
  logic [2:0] l_div_reg;
  logic l_tick;

  // Link clock divided by 8 for SCK, so SCK stays under 5 MHz for link clocks under 40 MHz
  assign l_tick = l_div_reg == 3'(`FPP_SCK_DIV - 1);

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst)
      l_div_reg <= 3'h0;
    else if (!l_act_reg || l_tick)
      l_div_reg <= 3'h0;
    else
      l_div_reg <= l_div_reg + 3'h1;
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      go_s_l <= 2'h0;
      go_seen_l <= 1'b0;
      l_sh_reg <= 8'h00;
      l_rx_reg <= 8'h00;
      l_bit_reg <= 4'h0;
      l_sck_reg <= 1'b0;
      l_act_reg <= 1'b0;
      l_done_tgl <= 1'b0;
    end else begin
      go_s_l <= {go_s_l[0], go_tgl_reg};
      if (!l_act_reg && go_s_l[1] != go_seen_l) begin
        go_seen_l <= go_s_l[1];
        l_sh_reg <= sh_tx_reg; // stable while toggle pending
        l_bit_reg <= 4'h0;
        l_act_reg <= 1'b1;
      end else if (l_act_reg && l_tick) begin
        // One SCK half period per divider wrap
        l_sck_reg <= ~l_sck_reg;
        if (l_sck_reg) begin
          l_sh_reg <= {l_sh_reg[6:0], 1'b0};
          if (l_bit_reg == 4'd7) begin
            l_act_reg <= 1'b0;
            l_done_tgl <= ~l_done_tgl;
          end
          l_bit_reg <= l_bit_reg + 4'd1;
        end else begin
          l_rx_reg <= {l_rx_reg[6:0], miso_in};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_s_s <= 2'h0;
      done_seen_reg <= 1'b0;
      rx_hold_reg <= 8'h00;
      busy_s_reg <= 2'h0;
      miso_s_reg <= 2'h0;
    end else begin
      done_s_s <= {done_s_s[0], l_done_tgl};
      done_seen_reg <= done_s_s[1];
      if (ser_done)
        rx_hold_reg <= l_rx_reg; // stable once done toggled
      busy_s_reg <= {busy_s_reg[0], busy_indicator_pin};
      miso_s_reg <= {miso_s_reg[0], miso_in};
    end
  end
  assign ser_done = done_s_s[1] != done_seen_reg;
  assign done_tgl_reg = l_done_tgl;

  //////////////////////////////////////////////////////////////////////
  // Main sequencer
  logic strobe_dn;
  assign strobe_dn = cnt_reg >= (`FPP_STROBE_CYC - 1);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      S_IDLE: if (seq_kind_reg != 3'd0) st_next = S_SEQ;
        else if (req_valid) st_next = req.serial ? S_SER : S_SETUP;
      S_SETUP: if (strobe_dn) st_next = S_HI;
      S_HI: if (strobe_dn) st_next = (is_rd && idx_reg == 3'd3) ?
          S_TURN : S_LO;
      S_LO: if (strobe_dn) st_next = (is_wr && idx_reg == 3'd5) ||
          (is_rd && idx_reg == 3'd4) ? S_END : S_HI;
      S_TURN: if (strobe_dn) st_next = S_SAMP;
      S_SAMP: if (strobe_dn) st_next = S_END;
      S_END: if (strobe_dn) st_next = is_wr ? S_WAIT : S_IDLE;
      S_WAIT: if (!busy_sync && cnt_reg >= 32'(PROG_CYC)) st_next = S_GAP;
      S_GAP: if (cnt_reg >= `FPP_GAP_CYC) st_next = S_IDLE;
      S_SER: if (ser_done && idx_reg == (is_rd ? 3'd4 : 3'd4))
          st_next = S_END;
      S_SEQ: if (seq_reg == 3'd4 && cnt_reg >= 32'(POR_CYC))
          st_next = S_IDLE;
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= S_IDLE;
      cnt_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= (st_next != st_reg) ? 32'h0 : cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '0;
      idx_reg <= 3'd0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      par_dout <= 8'h00;
      par_doe_n <= 1'b1;
      select_pin <= 1'b1;
      program_strobe <= 1'b0;
      go_tgl_reg <= 1'b0;
      sh_tx_reg <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= st_next == S_IDLE && seq_kind_reg == 3'd0;
      unique case (st_reg)
        S_IDLE: if (req_valid && seq_kind_reg == 3'd0) begin
          cur_reg <= req;
          idx_reg <= 3'd0;
          if (!req.serial) select_pin <= 1'b0;
        end
        S_SETUP: begin
          par_dout <= byte_w;
          par_doe_n <= 1'b0;
          if (strobe_dn) program_strobe <= 1'b1;
        end
        S_HI: if (strobe_dn) begin
          if (is_rd && idx_reg == 3'd3)
            par_doe_n <= 1'b1;
          else
            program_strobe <= 1'b0;
          idx_reg <= idx_reg + 3'd1;
        end
        S_LO: begin
          par_dout <= byte_w;
          if (strobe_dn && st_next == S_HI)
            program_strobe <= 1'b1;
        end
        S_TURN: if (strobe_dn) program_strobe <= 1'b0;
        S_SAMP: if (strobe_dn) begin
          rsp_data <= par_din;
          rsp_valid <= 1'b1;
        end
        S_END: begin
          par_doe_n <= 1'b1;
          select_pin <= 1'b1;
        end
        S_WAIT: ;
        S_GAP: ;
        S_SER: begin
          if (cnt_reg == 32'h0 || ser_done) begin
            if (ser_done) idx_reg <= idx_reg + 3'd1;
            if (!(ser_done && idx_reg == 3'd4)) begin
              sh_tx_reg <= ser_done ? sh_tx_reg : byte_w;
              go_tgl_reg <= ~go_tgl_reg;
            end
          end
          if (ser_done && idx_reg == 3'd4 && is_rd) begin
            rsp_data <= l_rx_reg;
            rsp_valid <= 1'b1;
          end
        end
        default: ;
      endcase
      if (st_reg == S_SER && ser_done && idx_reg != 3'd4) begin
        sh_tx_reg <= (idx_reg == 3'd3 && cur_reg.cmd == FPP_CMD_FUSE_WR) ?
          (cur_reg.data | ~FUSE_IMPL_MASK) :
          (idx_reg == 3'd3) ? cur_reg.data :
          (idx_reg == 3'd0) ? op_w : `FPP_ADDR_ZERO;
        go_tgl_reg <= ~go_tgl_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin sequences for power and serial-mode entry and exit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq_kind_reg <= 3'd0;
      seq_reg <= 3'd0;
      sck_out <= 1'b0;
      sck_oe_n <= 1'b1;
      ss_out <= 1'b1;
      ss_oe_n <= 1'b1;
      mosi_out <= 1'b0;
      mosi_oe_n <= 1'b1;
      dev_reset <= 1'b0;
      vcc_en <= 1'b0;
    end else begin
      // SS low frames a serial command; high again completes it
      if (st_reg == S_SER && !ss_oe_n)
        ss_out <= 1'b0;
      else if (st_reg == S_END && cur_reg.serial)
        ss_out <= 1'b1;
      if (st_reg == S_SER) begin
        sck_out <= l_sck_reg; // crossed via registered copy
        mosi_out <= l_sh_reg[7];
      end
      if (seq_kind_reg == 3'd0 && st_reg == S_IDLE) begin
        seq_reg <= 3'd0;
        if (pwr_up_req) seq_kind_reg <= 3'd1;
        else if (isp_enter_req) seq_kind_reg <= 3'd2;
        else if (isp_exit_req) seq_kind_reg <= 3'd3;
        else if (pwr_dn_req) seq_kind_reg <= 3'd4;
      end else if (st_reg == S_SEQ && cnt_reg[4:0] == 5'h1f) begin
        // Last step holds so a long reset wait never replays the pins
        if (seq_reg != 3'd4) seq_reg <= seq_reg + 3'd1;
        unique case (seq_kind_reg)
          3'd1: case (seq_reg)
            3'd0: begin vcc_en <= 1'b1; sck_oe_n <= 1'b0;
              sck_out <= 1'b0; ss_oe_n <= 1'b0; ss_out <= 1'b0; end
            3'd1: if (cnt_reg < `FPP_PWRUP_CYC) seq_reg <= seq_reg;
            3'd2: begin dev_reset <= 1'b1; ss_out <= 1'b1; end
            default: ;
          endcase
          3'd2: case (seq_reg)
            3'd0: begin ss_oe_n <= 1'b0; ss_out <= 1'b1; end
            3'd1: mosi_oe_n <= 1'b0;
            3'd2: dev_reset <= 1'b1;
            3'd3: begin sck_oe_n <= 1'b0; sck_out <= 1'b0; end
            default: ;
          endcase
          3'd3: case (seq_reg)
            3'd0: ss_out <= 1'b1;
            3'd1: mosi_oe_n <= 1'b1;
            3'd2: sck_oe_n <= 1'b1;
            3'd3: begin dev_reset <= 1'b0; ss_oe_n <= 1'b1; end
            default: ;
          endcase
          default: case (seq_reg)
            3'd0: mosi_oe_n <= 1'b1;
            3'd1: sck_out <= 1'b0;
            3'd2: dev_reset <= 1'b0;
            3'd3: begin ss_out <= 1'b0; vcc_en <= 1'b0; end
            default: ;
          endcase
        endcase
        if (seq_reg == 3'd4) seq_kind_reg <= 3'd0;
      end
      if (st_reg == S_SEQ && st_next == S_IDLE)
        seq_kind_reg <= 3'd0;
    end
  end
endmodule

// *** testbench/fpp_dev_model.sv ***
// Behavioural flash device answering the parallel and serial ports
`timescale 1ns/1ps
module fpp_dev_model #(
  parameter int BUSY_CYC = 200
) (
  input wire logic sys_clk,
  input wire logic select_pin,
  input wire logic program_strobe,
  input wire logic [7:0] par_dout,
  input wire logic par_doe_n,
  output logic [7:0] par_din,
  output logic busy_indicator_pin,
  input wire logic sck_out,
  input wire logic ss_out,
  input wire logic mosi_out,
  output logic miso_in,
  input wire logic vcc_en
);
  logic [7:0] cb [5];
  logic [7:0] rx, tx, rd, lock, fuse;
  logic drv, isp_live, mq;
  int nb, bc, bcnt;
  initial begin
    {lock, fuse, rx, tx, drv, isp_live, mq} = {8'hff, 8'hfe, 19'h0};
    {nb, bc, bcnt} = {32'h0, 32'h0, 32'h0};
  end
  assign busy_indicator_pin = bcnt != 0;
  assign rd = cb[1] == 8'h64 ? lock : cb[1] == 8'h61 ? fuse :
    {7'h0, busy_indicator_pin};
  // A released bus shows the complement so stale data never passes
  assign par_din = !par_doe_n ? par_dout : drv ? rd : ~par_dout;
  assign miso_in = ss_out ? ~mq : mq;
  task automatic put(input logic [7:0] v);
    if (nb < 5)
      cb[nb] = v;
    nb++;
  endtask
  task automatic fin(input logic ser);
    if (nb == 5 && cb[0] == 8'haa && cb[2] == 8'h00 && cb[3] == 8'h00 &&
        !(ser && !isp_live)) begin
      if (cb[1] == 8'he4)
        lock = cb[4];
      if (cb[1] == 8'he1)
        fuse = {cb[4][7:1], cb[4][0] & (fuse[0] | !ser)};
      if (cb[1][7])
        bcnt = BUSY_CYC;
    end
    nb = 0;
  endtask
  always @(posedge sys_clk) if (bcnt > 0) bcnt--;
  always @(negedge select_pin) nb = 0;
  always @(posedge program_strobe) if (!select_pin) put(par_din);
  always @(negedge program_strobe)
    if (!select_pin && nb == 4 && !cb[1][7]) drv = 1;
  always @(posedge select_pin) begin
    drv = 0;
    fin(0);
  end
  // Fuse changes reach the serial path only at the next power-up
  always @(posedge vcc_en) isp_live = fuse[0];
  always @(negedge ss_out) {nb, bc} = {32'h0, 32'h0};
  always @(posedge sck_out) if (!ss_out) begin
    rx = {rx[6:0], mosi_out};
    bc++;
    if (bc == 8) begin
      put(rx);
      bc = 0;
    end
  end
  always @(negedge sck_out) if (!ss_out && isp_live) begin
    mq = nb == 4 && bc == 0 ? rd[7] : tx[7];
    tx = nb == 4 && bc == 0 ? {rd[6:0], 1'b0} : {tx[6:0], 1'b0};
  end
  always @(posedge ss_out) fin(1);
endmodule

// *** testbench/fpp_host_chk.sv ***
// Protocol checker bound to the flash programming host controller
`timescale 1ns/1ps
module fpp_host_chk #(
  parameter logic [7:0] FUSE_IMPL_MASK = 8'hff
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic req_ready,
  input wire logic select_pin,
  input wire logic program_strobe,
  input wire logic [7:0] par_dout,
  input wire logic par_doe_n,
  input wire logic busy_indicator_pin,
  input wire logic sck_out,
  input wire logic ss_out,
  input wire logic mosi_out,
  input wire logic mosi_oe_n,
  input wire logic dev_reset
);
  logic [2:0] scnt;
  logic [7:0] op, gcnt;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst || select_pin) scnt <= 3'h0;
    else if ($rose(program_strobe)) scnt <= scnt + 3'h1;
  always_ff @(posedge sys_clk)
    if ($rose(program_strobe) && scnt == 3'h1) op <= par_dout;
  // Cycles since busy dropped, saturating so idle time never wraps
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) gcnt <= 8'hff;
    else if (busy_indicator_pin) gcnt <= 8'h00;
    else if (gcnt != 8'hff) gcnt <= gcnt + 8'h01;
  a_pre_first: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(program_strobe) && scnt == 3'h0 |-> par_dout == 8'haa)
    else $error("first strobed byte is not the preamble");
  a_bus_free: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(program_strobe) && scnt == 3'h4 && !op[7] |-> par_doe_n)
    else $error("bus still driven at read turnaround");
  a_stb_cnt: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(select_pin) |-> scnt == (op[7] ? 3'h5 : 3'h4))
    else $error("wrong strobe count in command");
  a_fuse_ones: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(program_strobe) && scnt == 3'h4 && op == 8'he1
    |-> (par_dout | FUSE_IMPL_MASK) == 8'hff)
    else $error("unimplemented fuse bit written as zero");
  a_write_gap: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(req_ready) |-> gcnt >= 8'h78)
    else $error("ready too soon after busy fell");
  a_mosi_hold: assert property (@(posedge link_clk) disable iff (rst)
    $rose(sck_out) |-> $stable(mosi_out))
    else $error("data out changed on rising serial clock");
  a_rst_ss_hi: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(dev_reset) |-> ss_out)
    else $error("device reset raised with select low");
  a_rst_fall: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(dev_reset) |-> mosi_oe_n && ss_out)
    else $error("device reset dropped too early");
  c_par_read: cover property (@(posedge sys_clk)
    $fell(program_strobe) && scnt == 3'h4 && !op[7]);
  c_fuse_wr: cover property (@(posedge sys_clk)
    $rose(select_pin) && op == 8'he1);
  c_ser_cmd: cover property (@(posedge link_clk) $rose(ss_out) && dev_reset);
endmodule
bind fpp_host fpp_host_chk #(.FUSE_IMPL_MASK(FUSE_IMPL_MASK)) fpp_host_chk_inst (
  .sys_clk, .rst, .link_clk, .req_ready, .select_pin, .program_strobe,
  .par_dout, .par_doe_n, .busy_indicator_pin, .sck_out, .ss_out, .mosi_out,
  .mosi_oe_n, .dev_reset);

// *** testbench/fpp_host_tb.sv ***
// Self-checking bench for the flash programming host controller
`timescale 1ns/1ps
module fpp_host_tb;
  import fpp_pkg::*;
  logic sys_clk = 0, rst = 1, link_clk = 0, req_valid = 0;
  logic pwr_up_req = 0, isp_enter_req = 0, isp_exit_req = 0, pwr_dn_req = 0;
  fpp_req_t req = '0;
  logic req_ready, rsp_valid, par_doe_n, select_pin, program_strobe, busy;
  logic sck_out, ss_out, mosi_out, miso_in, dev_reset, vcc_en;
  logic [7:0] rsp_data, par_dout, par_din, lock_e, fuse_e, got, d;
  fpp_cmd_t c;
  int num_errors = 0, compares = 0;
  always #12.5 sys_clk = ~sys_clk;
  initial #7 forever #24 link_clk = ~link_clk;
  fpp_host #(.PROG_CYC(100), .POR_CYC(100)) fpp_host_inst (.sys_clk, .rst,
    .link_clk, .req_valid, .req, .pwr_up_req, .isp_enter_req, .isp_exit_req,
    .pwr_dn_req, .req_ready, .rsp_valid, .rsp_data, .par_dout, .par_din,
    .par_doe_n, .select_pin, .program_strobe, .busy_indicator_pin(busy),
    .sck_out, .sck_oe_n(), .ss_out, .ss_oe_n(), .mosi_out, .mosi_oe_n(),
    .miso_in, .dev_reset, .vcc_en);
  fpp_dev_model #(.BUSY_CYC(200)) fpp_dev_model_inst (.sys_clk, .select_pin,
    .program_strobe, .par_dout, .par_doe_n, .par_din,
    .busy_indicator_pin(busy), .sck_out, .ss_out, .mosi_out, .miso_in,
    .vcc_en);
  task automatic close_out;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int n = 0;
    do @(posedge sys_clk); while (s !== 1'b1 && ++n < 20000);
    if (n >= 20000) begin
      num_errors++;
      close_out;
    end
  endtask
  task automatic run(input logic s, input logic st, input fpp_cmd_t k,
                     input logic [7:0] v);
    @(posedge sys_clk);
    #2 req_valid = 1;
    req = '{s, st, k, v};
    wait_hi(req_ready);
    #2 req_valid = 0;
    if (st || k[0]) begin
      wait_hi(rsp_valid);
      got = rsp_data;
    end
  endtask
  // Start strobes are single pulses; the sequences are left to finish
  task automatic pins(ref logic r);
    wait_hi(req_ready);
    #2 r = 1;
    @(posedge sys_clk);
    #2 r = 0;
    repeat (1000) @(posedge sys_clk);
  endtask
  function automatic logic [7:0] fuse_val(input logic [7:0] v);
    return v | ~8'hff;
  endfunction
  initial begin
    void'($urandom(32'h99ab));
    repeat (4) @(posedge sys_clk);
    #2 rst = 0;
    pins(pwr_up_req);
    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      d[0] = 1'b1;
      c = fpp_cmd_t'(i < 4 ? i : $urandom_range(3));
      run(1'b0, 1'b0, c, d);
      if (c == FPP_CMD_LOCK_WR)
        lock_e = d;
      if (c == FPP_CMD_FUSE_WR)
        fuse_e = fuse_val(d);
      if (c[0])
        chk(got, c[1] ? fuse_e : lock_e);
    end
    run(1'b0, 1'b1, FPP_CMD_LOCK_RD, 8'h00);
    chk(got, 8'h00);
    pins(pwr_dn_req);
    pins(pwr_up_req);
    pins(isp_enter_req);
    d = $urandom;
    run(1'b1, 1'b0, FPP_CMD_LOCK_WR, d);
    run(1'b1, 1'b0, FPP_CMD_LOCK_RD, 8'h00);
    chk(got, d);
    lock_e = d;
    run(1'b1, 1'b0, FPP_CMD_FUSE_WR, 8'hfe);
    run(1'b1, 1'b0, FPP_CMD_FUSE_RD, 8'h00);
    chk(got, fuse_val(8'hfe));
    pins(isp_exit_req);
    pins(pwr_dn_req);
    pins(pwr_up_req);
    pins(isp_enter_req);
    run(1'b1, 1'b0, FPP_CMD_LOCK_WR, ~d);
    run(1'b0, 1'b0, FPP_CMD_LOCK_RD, 8'h00);
    chk(got, lock_e);
    close_out;
  end
  initial begin
    #1ms;
    num_errors++;
    close_out;
  end
endmodule
